// ==== design/eprom_prog_defs.vh ====
// Function
// - Programmer presents byte, gate high, pulses select low
// - 100 us pulses, verify, abort after 25
// - Final read-back at normal supply compares all; the host read op returns the byte uncompared
// - Select held high during reads under program supply
// - Select decoded, gate tied to system read strobe (the host drives chip_sel_n and out_gate_n from its own state machine instead)
`ifndef EPROM_PROG_DEFS_VH
`define EPROM_PROG_DEFS_VH
`define CLK_FREQ_HZ        20000000
`define PULSE_TIME_US      100
`define PULSE_CYCLES       ((`PULSE_TIME_US * (`CLK_FREQ_HZ / 1000000)))
`define SETUP_TIME_US      2
`define SETUP_CYCLES       ((`SETUP_TIME_US * (`CLK_FREQ_HZ / 1000000)))
`define VERIFY_WAIT_CYCLES 4
`define MAX_PULSES         25
`define ERASED_BYTE        8'hff
`define ID_ADDR_MASK       15'h1ffe
`define ADDR_W             15
`endif

// ==== design/eprom_timer.v ====
`timescale 1ns/10ps
`default_nettype none
// Down-counter for the pulse and setup waits
module eprom_timer #(
    parameter W = 12
) (
    // Clock and reset
    input  wire         clk_sys,
    input  wire         nrst,
    // Control
    input  wire         load,
    input  wire [W-1:0] count,
    output wire         done
);
    reg [W-1:0] cnt_r;

    always @(posedge clk_sys) begin
        if (!nrst)
            cnt_r <= {W{1'b0}};
        else if (load)
            cnt_r <= count;
        else if (cnt_r != {W{1'b0}})
            cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
    end

    assign done = (cnt_r == {W{1'b0}}) & ~load;
endmodule // eprom_timer
`default_nettype wire

// ==== design/eprom_prog_host.v ====
`timescale 1ns/10ps
`default_nettype none
`include "eprom_prog_defs.vh"
// Programmer for the latched-address EPROM: program, verify, read and identify.
module eprom_prog_host #(
    parameter PULSE_CNT = `PULSE_CYCLES,
    parameter SETUP_CNT = `SETUP_CYCLES,
    parameter MAX_TRIES = `MAX_PULSES
) (
    // Clock and reset
    input  wire        clk_sys,
    input  wire        nrst,
    // User command
    input  wire        cmd_valid,
    input  wire [1:0]  cmd_op,
    input  wire [14:0] cmd_addr,
    input  wire [7:0]  cmd_data,
    output reg         cmd_ready,
    output reg         rsp_valid,
    output reg  [7:0]  rsp_data,
    output reg         rsp_error,
    // Device pins
    output reg  [14:0] addr_out,
    output reg         id_mode_address_line_hv,
    output reg         prog_supply_hv,
    output reg         core_supply_hi,
    output reg         addr_hold_strobe,
    output reg         chip_sel_n,
    output reg         out_gate_n,
    output reg  [7:0]  byte_outputs_o,
    output reg         byte_outputs_oe,
    input  wire [7:0]  byte_outputs_i
);
    localparam OP_READ = 2'd0;
    localparam OP_PROG = 2'd1;
    localparam OP_ID   = 2'd2;
    localparam OP_VFY  = 2'd3;

    // The timer answers two cycles after its load is requested, so the pulse
    // load is cut by that much to keep the select-low time at PULSE_CNT cycles
    localparam integer PULSE_LOAD  = PULSE_CNT - 2;
    localparam integer VERIFY_LOAD = `VERIFY_WAIT_CYCLES;

    localparam S_IDLE  = 4'd0;
    localparam S_SETUP = 4'd1;
    localparam S_PULSE = 4'd2;
    localparam S_HOLD  = 4'd3;
    localparam S_VGATE = 4'd4;
    localparam S_VSAMP = 4'd5;
    localparam S_RLAT  = 4'd6;
    localparam S_RGATE = 4'd7;
    localparam S_RSAMP = 4'd8;
    localparam S_DONE  = 4'd9;

    reg [3:0]  state_r;
    reg [1:0]  op_r;
    reg [7:0]  data_r;
    reg [4:0]  tries_r;
    reg [7:0]  sync1_r;
    reg [7:0]  sync2_r;
    reg        t_load;
    reg [11:0] t_count;
    wire       t_done;

    eprom_timer #(.W(12)) u_timer (
        .clk_sys (clk_sys),
        .nrst    (nrst),
        .load    (t_load),
        .count   (t_count),
        .done    (t_done)
    );

    // Device data returns asynchronously, so it is synchronised first
    always @(posedge clk_sys) begin
        if (!nrst) begin
            sync1_r <= 8'h00;
            sync2_r <= 8'h00;
        end else begin
            sync1_r <= byte_outputs_i;
            sync2_r <= sync1_r;
        end
    end

    always @(posedge clk_sys) begin
        if (!nrst) begin
            state_r                 <= S_IDLE;
            op_r                    <= 2'h0;
            data_r                  <= 8'h00;
            tries_r                 <= 5'h00;
            t_load                  <= 1'b0;
            t_count                 <= 12'h000;
            cmd_ready               <= 1'b0;
            rsp_valid               <= 1'b0;
            rsp_data                <= 8'h00;
            rsp_error               <= 1'b0;
            addr_out                <= 15'h0000;
            id_mode_address_line_hv <= 1'b0;
            prog_supply_hv          <= 1'b0;
            core_supply_hi          <= 1'b0;
            addr_hold_strobe        <= 1'b1;
            chip_sel_n              <= 1'b1;
            out_gate_n              <= 1'b1;
            byte_outputs_o          <= 8'h00;
            byte_outputs_oe         <= 1'b0;
        end else begin
            t_load    <= 1'b0;
            rsp_valid <= 1'b0;
            cmd_ready <= 1'b0;
            case (state_r)
                S_IDLE: begin
                    chip_sel_n       <= 1'b1;
                    out_gate_n       <= 1'b1;
                    byte_outputs_oe  <= 1'b0;
                    addr_hold_strobe <= 1'b1;
                    cmd_ready        <= ~cmd_valid;
                    if (cmd_valid && cmd_ready) begin
                        op_r    <= cmd_op;
                        data_r  <= cmd_data;
                        tries_r <= 5'h00;
                        t_load  <= 1'b1;
                        t_count <= SETUP_CNT[11:0];
                        if (cmd_op == OP_ID) begin
                            // Code select on line 0, rest of identification lines low
                            addr_out <= {cmd_addr[14:13], 12'h000, cmd_addr[0]};
                            id_mode_address_line_hv <= 1'b1;
                            state_r <= S_RLAT;
                        end else if (cmd_op == OP_READ) begin
                            addr_out <= cmd_addr;
                            prog_supply_hv <= 1'b0;
                            core_supply_hi <= 1'b0;
                            state_r <= S_RLAT;
                        end else begin
                            addr_out       <= cmd_addr;
                            prog_supply_hv <= 1'b1;
                            core_supply_hi <= 1'b1;
                            state_r <= (cmd_op == OP_PROG) ? S_SETUP : S_VGATE;
                        end
                    end
                end
                S_SETUP: begin
                    // Data on pins with gate high, then select pulse
                    out_gate_n      <= 1'b1;
                    byte_outputs_o  <= data_r;
                    byte_outputs_oe <= 1'b1;
                    if (t_done) begin
                        chip_sel_n <= 1'b0;
                        tries_r    <= tries_r + 5'd1;
                        t_load     <= 1'b1;
                        t_count    <= PULSE_LOAD[11:0];
                        state_r    <= S_PULSE;
                    end
                end
                S_PULSE: if (t_done) begin
                    chip_sel_n <= 1'b1;
                    t_load     <= 1'b1;
                    t_count    <= SETUP_CNT[11:0];
                    state_r    <= S_HOLD;
                end
                S_HOLD: if (t_done) begin
                    byte_outputs_oe <= 1'b0;
                    t_load          <= 1'b1;
                    t_count         <= SETUP_CNT[11:0];
                    state_r         <= S_VGATE;
                end
                S_VGATE: if (t_done) begin
                    // Verify with select high keeps device from programming
                    chip_sel_n <= 1'b1;
                    out_gate_n <= 1'b0;
                    t_load     <= 1'b1;
                    t_count    <= VERIFY_LOAD[11:0];
                    state_r    <= S_VSAMP;
                end
                S_VSAMP: if (t_done) begin
                    out_gate_n <= 1'b1;
                    rsp_data   <= sync2_r;
                    if (op_r == OP_VFY || sync2_r == data_r) begin
                        rsp_error <= (op_r == OP_PROG) ? 1'b0 : (sync2_r != data_r);
                        state_r   <= S_DONE;
                    end else if (tries_r >= MAX_TRIES[4:0]) begin
                        rsp_error <= 1'b1;
                        state_r   <= S_DONE;
                    end else begin
                        t_load  <= 1'b1;
                        t_count <= SETUP_CNT[11:0];
                        state_r <= S_SETUP;
                    end
                end
                S_RLAT: if (t_done) begin
                    // Falling strobe latches address before bus turns to data
                    addr_hold_strobe <= 1'b0;
                    chip_sel_n       <= 1'b0;
                    state_r          <= S_RGATE;
                end
                S_RGATE: begin
                    out_gate_n <= 1'b0;
                    t_load     <= 1'b1;
                    t_count    <= VERIFY_LOAD[11:0];
                    state_r    <= S_RSAMP;
                end
                S_RSAMP: if (t_done) begin
                    rsp_data  <= sync2_r;
                    rsp_error <= 1'b0;
                    state_r   <= S_DONE;
                end
                S_DONE: begin
                    chip_sel_n              <= 1'b1;
                    out_gate_n              <= 1'b1;
                    byte_outputs_oe         <= 1'b0;
                    addr_hold_strobe        <= 1'b1;
                    prog_supply_hv          <= 1'b0;
                    core_supply_hi          <= 1'b0;
                    id_mode_address_line_hv <= 1'b0;
                    rsp_valid               <= 1'b1;
                    state_r                 <= S_IDLE;
                end
                default: state_r <= S_IDLE;
            endcase
        end
    end
endmodule // eprom_prog_host
`default_nettype wire

// ==== verification/eprom_host_monitor.sv ====
`timescale 1ns/10ps
`default_nettype none
module eprom_host_monitor #(
    parameter PULSE_CNT = 20
) (
    // Clock and reset
    input wire logic        clk_sys,
    input wire logic        nrst,
    // Device pins
    input wire logic [14:0] addr_out,
    input wire logic        prog_supply_hv,
    input wire logic        core_supply_hi,
    input wire logic        chip_sel_n,
    input wire logic        out_gate_n,
    input wire logic [7:0]  byte_outputs_o,
    input wire logic        byte_outputs_oe
);
    logic [15:0] lo_r;
    always @(posedge clk_sys) begin
        lo_r <= chip_sel_n ? 16'h0 : lo_r + 16'h1;
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    sequence pulse_end_s; $rose(chip_sel_n) && prog_supply_hv; endsequence
    sequence pulse_on_s; !chip_sel_n && prog_supply_hv ##1 !chip_sel_n; endsequence
    // Pulse may stray five percent either way
    pulse_width_a: assert property (pulse_end_s |-> lo_r >= PULSE_CNT*95/100
        && lo_r <= PULSE_CNT*105/100) else $error("program pulse width wrong");
    pulse_hold_a: assert property (pulse_on_s |-> $stable(byte_outputs_o)
        && $stable(addr_out)) else $error("data or address moved in pulse");
    prog_gate_a: assert property (!chip_sel_n && prog_supply_hv |->
        out_gate_n && byte_outputs_oe) else $error("pulse without driven data");
    verify_sel_a: assert property (prog_supply_hv && !out_gate_n |-> chip_sel_n)
        else $error("select low in verify read");
    no_clash_a: assert property (byte_outputs_oe |-> out_gate_n)
        else $error("both sides drive the byte lines");
    final_read_a: assert property (!chip_sel_n && !out_gate_n |->
        !core_supply_hi && !prog_supply_hv) else $error("read not at normal supply");
endmodule // eprom_host_monitor
`default_nettype wire

// ==== verification/eprom_dev_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module eprom_dev_model #(
    parameter [7:0] MAKER_CODE = 8'h3c, // Arbitrary value
    parameter [7:0] PART_CODE  = 8'hc3  // Arbitrary value
) (
    // Pins from the host
    input  wire logic [14:0] addr,
    input  wire logic        id_hv,
    input  wire logic        prog_hv,
    input  wire logic        strobe,
    input  wire logic        cs_n,
    input  wire logic        oe_n,
    input  wire logic [7:0]  din,
    // Cells refuse to program
    input  wire logic        stuck,
    output logic      [7:0]  dq
);
    logic [7:0]  mem [0:32767];
    logic [14:0] lat;
    logic [7:0]  last;
    wire  [14:0] ea  = (prog_hv || id_hv || strobe) ? addr : lat;
    wire         drv = !oe_n && (!cs_n || prog_hv);
    wire  [7:0]  rd  = id_hv ? (addr[0] ? PART_CODE : MAKER_CODE) : mem[ea];
    initial for (int i = 0; i < 32768; i++) mem[i] = 8'hff;
    always @(negedge strobe) lat = addr;
    // Bits only clear; a held-high select never writes
    always @(posedge cs_n) if (prog_hv && oe_n && !stuck) mem[ea] = mem[ea] & din;
    always @* if (drv) last = rd;
    // Released lines show the inverse so a stale byte cannot pass
    assign dq = drv ? rd : ~last;
endmodule // eprom_dev_model
`default_nettype wire

// ==== verification/eprom_prog_host_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module eprom_prog_host_tb;
    localparam PULSE_CNT = 20, MAX_TRIES = 25;
    localparam logic [7:0] MAKER = 8'h3c, PART = 8'hc3; // Arbitrary values
    logic        clk_sys = 1'h0, nrst = 1'h0, cmd_valid = 1'h0, stuck = 1'h0, got_e;
    logic [1:0]  cmd_op = 2'h0;
    logic [14:0] cmd_addr = 15'h0;
    logic [7:0]  cmd_data = 8'h0, got_d;
    wire         cmd_ready, rsp_valid, rsp_error, id_mode_address_line_hv, prog_supply_hv;
    wire         core_supply_hi, addr_hold_strobe, chip_sel_n, out_gate_n, byte_outputs_oe;
    wire  [14:0] addr_out;
    wire  [7:0]  rsp_data, byte_outputs_o, dev_q;
    wire  [7:0]  byte_outputs_i = byte_outputs_oe ? byte_outputs_o : dev_q;
    int          n_errors = 0, comparisons = 0, n_pulse = 0;
    // Op, address, data, expected byte, expected error
    logic [33:0] rows [10] = '{{2'h1,15'h123,8'ha5,8'ha5,1'h0}, {2'h0,15'h123,8'h0,8'ha5,1'h0},
        {2'h1,15'h7fff,8'h3c,8'h3c,1'h0}, {2'h0,15'h7fff,8'h0,8'h3c,1'h0},
        {2'h0,15'h1,8'h0,8'hff,1'h0}, {2'h2,15'h0,8'h0,MAKER,1'h0}, {2'h2,15'h1,8'h0,PART,1'h0},
        {2'h3,15'h123,8'ha5,8'ha5,1'h0}, {2'h3,15'h123,8'h0,8'ha5,1'h1},
        {2'h1,15'h123,8'hff,8'ha5,1'h1}};
    eprom_prog_host #(.PULSE_CNT(PULSE_CNT), .SETUP_CNT(4), .MAX_TRIES(MAX_TRIES)) dut_u (
        .clk_sys, .nrst, .cmd_valid, .cmd_op, .cmd_addr, .cmd_data, .cmd_ready, .rsp_valid,
        .rsp_data, .rsp_error, .addr_out, .id_mode_address_line_hv, .prog_supply_hv,
        .core_supply_hi, .addr_hold_strobe, .chip_sel_n, .out_gate_n, .byte_outputs_o,
        .byte_outputs_oe, .byte_outputs_i);
    eprom_dev_model #(.MAKER_CODE(MAKER), .PART_CODE(PART)) dev_u (.addr(addr_out),
        .id_hv(id_mode_address_line_hv), .prog_hv(prog_supply_hv), .strobe(addr_hold_strobe),
        .cs_n(chip_sel_n), .oe_n(out_gate_n), .din(byte_outputs_o), .stuck, .dq(dev_q));
    initial forever #25 clk_sys = ~clk_sys;
    always @(negedge chip_sel_n) if (prog_supply_hv === 1'h1) n_pulse++;
    task chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task run(input logic [1:0] op, input logic [14:0] a, input logic [7:0] d);
        // Ready only rises while no request stands, so ask only once it is up
        repeat (50) if (cmd_ready !== 1'h1) @(posedge clk_sys);
        cmd_op <= op;
        cmd_addr <= a;
        cmd_data <= d;
        cmd_valid <= 1'h1;
        @(posedge clk_sys);
        repeat (50) if (cmd_ready !== 1'h1) @(posedge clk_sys);
        cmd_valid <= 1'h0;
        repeat (5000) if (rsp_valid !== 1'h1) @(posedge clk_sys);
        chk({7'h0, rsp_valid}, 8'h01);
        got_d = rsp_data;
        got_e = rsp_error;
    endtask
    task end_of_test;
        $display("errors=%0d comparisons=%0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge clk_sys);
        nrst <= 1'h1;
        foreach (rows[i]) begin
            run(rows[i][33:32], rows[i][31:17], rows[i][16:9]);
            chk(got_d, rows[i][8:1]);
            chk({7'h0, got_e}, {7'h0, rows[i][0]});
            $display("row %0d done", i);
        end
        stuck <= 1'h1;
        n_pulse = 0;
        run(2'h1, 15'h200, 8'h0);
        chk({7'h0, got_e}, 8'h01);
        chk(got_d, 8'hff);
        chk(n_pulse[7:0], 8'(MAX_TRIES));
        $display("retry limit test done");
        stuck <= 1'h0;
        cmd_valid <= 1'h1;
        repeat (12) @(posedge clk_sys);
        nrst <= 1'h0;
        cmd_valid <= 1'h0;
        repeat (2) @(posedge clk_sys);
        #1 chk({5'h0, chip_sel_n, prog_supply_hv, byte_outputs_oe}, 8'h04);
        @(posedge clk_sys);
        nrst <= 1'h1;
        run(2'h0, 15'h123, 8'h0);
        chk(got_d, 8'ha5);
        $display("reset test done");
        end_of_test;
    end
    initial begin
        #(20000 * 50);
        n_errors++;
        end_of_test;
    end
endmodule // eprom_prog_host_tb
bind eprom_prog_host eprom_host_monitor #(.PULSE_CNT(PULSE_CNT)) mon_u (.clk_sys, .nrst,
    .addr_out, .prog_supply_hv, .core_supply_hi, .chip_sel_n, .out_gate_n, .byte_outputs_o,
    .byte_outputs_oe);
`default_nettype wire
